/* rtl/imnp_pkg.sv */
package imnp_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_LOCK = 8'h0C;
    localparam logic [7:0] REG_NVM = 8'h10;
    localparam logic [7:0] REG_CALIB = 8'h14;

    // ------------------------------------------------------------------
    // Command register fields and opcodes
    // ------------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 4;
    localparam int CMD_ARG_LSB = 8;
    localparam int PAGE_W = 11;
    localparam logic [3:0] OP_PROG_PAGE = 4'h1;
    localparam logic [3:0] OP_ERASE_PAGE = 4'h2;
    localparam logic [3:0] OP_ERASE_ALL = 4'h3;
    localparam logic [3:0] OP_SET_LOCK = 4'h4;
    localparam logic [3:0] OP_CLR_LOCK = 4'h5;
    localparam logic [3:0] OP_SET_GENERAL_NONVOLATILE_BIT = 4'h6;
    localparam logic [3:0] OP_CLR_GENERAL_NONVOLATILE_BIT = 4'h7;
    localparam logic [3:0] OP_SET_SECURITY = 4'h8;
    localparam logic [3:0] OP_REMAP = 4'h9;

    // ------------------------------------------------------------------
    // Status, control and non-volatile view bit positions
    // ------------------------------------------------------------------
    localparam int ST_DONE = 0;
    localparam int ST_LOCK_ERR = 1;
    localparam int ST_BUSY_ERR = 2;
    localparam int ST_BUSY_LSB = 4;
    localparam int CTRL_DONE_IE = 0;
    localparam int NV_GP_LSB = 0;
    localparam int NV_SECURITY = 4;
    localparam int NV_REMAP = 8;
    localparam int NV_FAST_PROG = 9;
    localparam int GP_BROWNOUT = 0;
    localparam int GP_BROWNOUT_RST = 1;
    localparam int GP_BOOT_FLASH = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] GENERAL_NONVOLATILE_BIT_RST = 3'h0;
    localparam logic [31:0] LOCK_RST = 32'h0;
    localparam logic SECURITY_RST = 1'b0;
    // Factory calibration pattern; value is arbitrary
    localparam logic [15:0] CALIB_VALUE = 16'hA5C3;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [31:0] BOOT_ALIAS_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
    localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
    localparam logic [31:0] ROM_BASE = 32'h0030_0000;
    localparam logic [3:0] AREA_INTERNAL = 4'h0;
    localparam logic [3:0] AREA_EXT_FIRST = 4'h1;
    localparam logic [3:0] AREA_EXT_LAST = 4'h8;
    localparam logic [3:0] AREA_PERIPH = 4'hF;

    // ------------------------------------------------------------------
    // Flash geometry and timing
    // ------------------------------------------------------------------
    localparam int PLANES = 2;
    localparam int PLANE_BIT = 18;
    localparam int PAGES_PER_PLANE = 1024;
    localparam int WBUF_WORDS = 64;
    localparam int LOCKS_BIG = 32;
    localparam int LOCKS_SMALL = 8;
    localparam int REGION_SHIFT_BIG = 6;
    localparam int REGION_SHIFT_SMALL = 5;
    localparam logic [15:0] CMD_CYCLES = 16'h0010;

    typedef enum logic [2:0] {
        TGT_FLASH, TGT_SRAM, TGT_ROM, TGT_EXT, TGT_PERIPH, TGT_ABORT
    } imnp_target_type;

endpackage : imnp_pkg

/* rtl/imnp_addr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module imnp_addr_decode (
    input wire logic [31:0] addr,
    input wire logic remap,
    input wire logic boot_flash,
    output imnp_pkg::imnp_target_type target,
    output logic [19:0] offset
);
    import imnp_pkg::*;

    // --------------------
    // Decode
    // --------------------
    function automatic imnp_target_type decode(input logic [31:0] a, input logic rm,
                                                input logic bf);
        imnp_target_type t;
        t = TGT_ABORT;
        if (a[31:28] == AREA_INTERNAL) begin
            if (a[27:20] == BOOT_ALIAS_BASE[27:20]) begin
                if (rm) begin
                    t = TGT_SRAM;
                end else if (bf) begin
                    t = TGT_FLASH;
                end else begin
                    t = TGT_ROM;
                end
            end else if (a[27:20] == FLASH_BASE[27:20]) begin
                t = TGT_FLASH;
            end else if (a[27:20] == SRAM_BASE[27:20]) begin
                t = TGT_SRAM;
            end else if (a[27:20] == ROM_BASE[27:20]) begin
                t = TGT_ROM;
            end
        end else if (a[31:28] >= AREA_EXT_FIRST && a[31:28] <= AREA_EXT_LAST) begin
            t = TGT_EXT;
        end else if (a[31:28] == AREA_PERIPH) begin
            t = TGT_PERIPH;
        end
        return t;
    endfunction : decode

    always_comb begin
        target = decode(addr, remap, boot_flash);
        offset = addr[19:0];
    end

endmodule : imnp_addr_decode
`default_nettype wire

/* rtl/imnp_top.sv */
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module imnp_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sys_valid,
    input wire logic sys_write,
    input wire logic sys_debug,
    input wire logic [31:0] sys_addr,
    input wire logic [31:0] sys_wdata,
    output imnp_pkg::imnp_target_type sys_target,
    output logic [19:0] mem_offset,
    output logic sys_abort,
    output logic sys_refused,
    output logic flash_wait,
    output logic flash_rd_req,
    output logic [19:0] flash_rd_addr,
    input wire logic [63:0] flash_dword,
    input wire logic flash_dword_valid,
    output logic [31:0] sys_rdata,
    output logic sys_rvalid,
    input wire logic [5:0] wbuf_idx,
    output logic [31:0] wbuf_word,
    output logic nvm_prog,
    output logic nvm_erase_page,
    output logic nvm_erase_all,
    output logic [imnp_pkg::PAGE_W-1:0] nvm_page,
    output logic [1:0] plane_busy,
    input wire logic small_variant,
    input wire logic wipe_pin,
    input wire logic test_mode_pin,
    input wire logic prog_select_pin_a,
    input wire logic prog_select_pin_b,
    input wire logic prog_select_pin_c,
    output logic fast_prog_active,
    output logic brownout_monitor_en,
    output logic brownout_reset_en,
    output logic remap_done,
    output logic cmd_irq
);
    import imnp_pkg::*;

    // --------------------
    // State
    // --------------------
    logic remap_q, remap_d;
    logic [2:0] general_nonvolatile_bit_q, general_nonvolatile_bit_d;
    logic [31:0] lock_q, lock_d;
    logic sec_q, sec_d;
    logic done_q, done_d;
    logic lock_err_q, lock_err_d;
    logic busy_err_q, busy_err_d;
    logic done_ie_q, done_ie_d;
    logic wipe_q, wipe_d;
    logic all_q, all_d;
    logic [15:0] cnt_q [PLANES];
    logic [15:0] cnt_d [PLANES];
    logic [31:0] wbuf_q [WBUF_WORDS];
    logic [31:0] wbuf_d [WBUF_WORDS];
    logic [31:0] wbuf_word_d;
    logic [31:0] rdata_q, rdata_d;
    logic [28:0] pf_tag_q, pf_tag_d;
    logic [63:0] pf_data_q, pf_data_d;
    logic pf_valid_q, pf_valid_d;
    logic pend_q, pend_d;
    logic pend_hi_q, pend_hi_d;
    logic [31:0] sys_rdata_d;
    logic sys_rvalid_d;
    logic prog_q, prog_d;
    logic erase_pg_q, erase_pg_d;
    logic erase_all_q, erase_all_d;
    logic [PAGE_W-1:0] page_q, page_d;

    logic [3:0] op;
    logic [PAGE_W-1:0] arg;
    logic [4:0] region;
    logic arg_plane, cmd_wr, flash_hit, acc_plane, pf_hit;

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [4:0] region_of(input logic [PAGE_W-1:0] pg, input logic sm);
        logic [PAGE_W-1:0] r;
        r = sm ? (pg >> REGION_SHIFT_SMALL) : (pg >> REGION_SHIFT_BIG);
        return r[4:0];
    endfunction : region_of

    function automatic logic [31:0] region_mask(input logic sm);
        return sm ? ((32'h1 << LOCKS_SMALL) - 32'h1) : 32'hFFFF_FFFF;
    endfunction : region_mask

    // --------------------
    // Address decode
    // --------------------
    imnp_addr_decode u_decode (
        .addr(sys_addr),
        .remap(remap_q),
        .boot_flash(general_nonvolatile_bit_q[GP_BOOT_FLASH]),
        .target(sys_target),
        .offset(mem_offset)
    );

    assign fast_prog_active = test_mode_pin & prog_select_pin_a & prog_select_pin_b
                              & ~prog_select_pin_c;
    assign sys_abort = sys_valid & (sys_target == TGT_ABORT);
    assign sys_refused = sys_valid & (sys_target == TGT_FLASH) & sec_q
                         & (sys_debug | fast_prog_active);
    assign flash_hit = sys_valid & (sys_target == TGT_FLASH) & ~sys_refused;
    assign acc_plane = mem_offset[PLANE_BIT];
    // Other plane stays readable while one programs
    assign flash_wait = flash_hit & (cnt_q[acc_plane] != 16'h0000 || pend_q);
    assign pf_hit = pf_valid_q & (pf_tag_q == sys_addr[31:3]);
    assign flash_rd_req = flash_hit & ~sys_write & ~pf_hit & ~flash_wait;
    assign flash_rd_addr = {mem_offset[19:3], 3'h0};

    assign op = reg_wdata[CMD_OP_LSB +: CMD_OP_W];
    assign arg = reg_wdata[CMD_ARG_LSB +: PAGE_W];
    assign arg_plane = arg[PAGE_W-1];
    assign region = region_of(arg, small_variant);
    assign cmd_wr = reg_wr & (reg_addr == REG_CMD);

    // --------------------
    // Control next state
    // --------------------
    always_comb begin
        remap_d = remap_q;
        general_nonvolatile_bit_d = general_nonvolatile_bit_q;
        lock_d = lock_q;
        sec_d = sec_q;
        done_d = done_q;
        lock_err_d = lock_err_q;
        busy_err_d = busy_err_q;
        done_ie_d = done_ie_q;
        wipe_d = wipe_pin;
        all_d = all_q;
        cnt_d = cnt_q;
        prog_d = 1'b0;
        erase_pg_d = 1'b0;
        erase_all_d = 1'b0;
        page_d = page_q;
        // Status read clears sticky flags; a new event below wins
        if (reg_rd && reg_addr == REG_STATUS) begin
            done_d = 1'b0;
            lock_err_d = 1'b0;
            busy_err_d = 1'b0;
        end
        if (reg_wr && reg_addr == REG_CTRL) begin
            done_ie_d = reg_wdata[CTRL_DONE_IE];
        end
        for (int p = 0; p < PLANES; p++) begin
            if (cnt_q[p] != 16'h0000) begin
                cnt_d[p] = cnt_q[p] - 16'h0001;
                if (cnt_q[p] == 16'h0001) begin
                    done_d = 1'b1;
                end
            end
        end
        if (all_q && cnt_q[0] == 16'h0001) begin
            all_d = 1'b0;
            if (wipe_pin) begin
                sec_d = 1'b0;
            end
        end
        if (cmd_wr) begin
            unique case (op)
                OP_PROG_PAGE, OP_ERASE_PAGE: begin
                    if (cnt_q[arg_plane] != 16'h0000) begin
                        busy_err_d = 1'b1;
                    end else if (lock_q[region]) begin
                        lock_err_d = 1'b1;
                    end else begin
                        cnt_d[arg_plane] = CMD_CYCLES;
                        prog_d = (op == OP_PROG_PAGE);
                        erase_pg_d = (op == OP_ERASE_PAGE);
                        page_d = arg;
                    end
                end
                OP_ERASE_ALL: begin
                    if (cnt_q[0] != 16'h0000 || cnt_q[1] != 16'h0000) begin
                        busy_err_d = 1'b1;
                    end else if ((lock_q & region_mask(small_variant)) != 32'h0) begin
                        lock_err_d = 1'b1;
                    end else begin
                        cnt_d[0] = CMD_CYCLES;
                        cnt_d[1] = CMD_CYCLES;
                        all_d = 1'b1;
                        erase_all_d = 1'b1;
                    end
                end
                OP_SET_LOCK: lock_d[region] = 1'b1;
                OP_CLR_LOCK: lock_d[region] = 1'b0;
                OP_SET_GENERAL_NONVOLATILE_BIT: begin
                    if (arg < PAGE_W'(3)) begin
                        general_nonvolatile_bit_d[arg[1:0]] = 1'b1;
                    end
                end
                OP_CLR_GENERAL_NONVOLATILE_BIT: begin
                    if (arg < PAGE_W'(3)) begin
                        general_nonvolatile_bit_d[arg[1:0]] = 1'b0;
                    end
                end
                OP_SET_SECURITY: sec_d = 1'b1;
                OP_REMAP: remap_d = 1'b1;
                default: busy_err_d = busy_err_q;
            endcase
        end
        // Wipe pin overrides lock and general-purpose bit commands of the same cycle
        if (wipe_pin) begin
            general_nonvolatile_bit_d = GENERAL_NONVOLATILE_BIT_RST;
            lock_d = LOCK_RST;
        end
        // Wipe rising edge launches an internal full erase
        if (wipe_pin && !wipe_q && !all_q) begin
            cnt_d[0] = CMD_CYCLES;
            cnt_d[1] = CMD_CYCLES;
            all_d = 1'b1;
            erase_all_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            remap_q <= 1'b0;
            general_nonvolatile_bit_q <= GENERAL_NONVOLATILE_BIT_RST;
            lock_q <= LOCK_RST;
            sec_q <= SECURITY_RST;
            done_q <= 1'b0;
            lock_err_q <= 1'b0;
            busy_err_q <= 1'b0;
            done_ie_q <= 1'b0;
            wipe_q <= 1'b0;
            all_q <= 1'b0;
            prog_q <= 1'b0;
            erase_pg_q <= 1'b0;
            erase_all_q <= 1'b0;
            page_q <= '0;
            for (int p = 0; p < PLANES; p++) begin
                cnt_q[p] <= 16'h0000;
            end
        end else begin
            remap_q <= remap_d;
            general_nonvolatile_bit_q <= general_nonvolatile_bit_d;
            lock_q <= lock_d;
            sec_q <= sec_d;
            done_q <= done_d;
            lock_err_q <= lock_err_d;
            busy_err_q <= busy_err_d;
            done_ie_q <= done_ie_d;
            wipe_q <= wipe_d;
            all_q <= all_d;
            prog_q <= prog_d;
            erase_pg_q <= erase_pg_d;
            erase_all_q <= erase_all_d;
            page_q <= page_d;
            cnt_q <= cnt_d;
        end
    end

    // --------------------
    // Page write buffer and prefetch
    // --------------------
    always_comb begin
        wbuf_d = wbuf_q;
        if (flash_hit && sys_write) begin
            wbuf_d[mem_offset[7:2]] = sys_wdata;
        end
        wbuf_word_d = wbuf_q[wbuf_idx];
        pf_tag_d = pf_tag_q;
        pf_data_d = pf_data_q;
        pf_valid_d = pf_valid_q;
        pend_d = pend_q;
        pend_hi_d = pend_hi_q;
        sys_rdata_d = 32'h0;
        sys_rvalid_d = 1'b0;
        // Writes or erases make cached words stale
        if (prog_q || erase_pg_q || erase_all_q) begin
            pf_valid_d = 1'b0;
        end
        if (pend_q && flash_dword_valid) begin
            pf_data_d = flash_dword;
            pf_valid_d = 1'b1;
            pend_d = 1'b0;
            sys_rdata_d = pend_hi_q ? flash_dword[63:32] : flash_dword[31:0];
            sys_rvalid_d = 1'b1;
        end else if (flash_hit && !sys_write && pf_hit && !pend_q) begin
            sys_rdata_d = sys_addr[2] ? pf_data_q[63:32] : pf_data_q[31:0];
            sys_rvalid_d = 1'b1;
        end else if (flash_rd_req) begin
            pf_tag_d = sys_addr[31:3];
            pf_valid_d = 1'b0;
            pend_d = 1'b1;
            pend_hi_d = sys_addr[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < WBUF_WORDS; i++) begin
                wbuf_q[i] <= 32'h0;
            end
            wbuf_word <= 32'h0;
            pf_tag_q <= '0;
            pf_data_q <= 64'h0;
            pf_valid_q <= 1'b0;
            pend_q <= 1'b0;
            pend_hi_q <= 1'b0;
            sys_rdata <= 32'h0;
            sys_rvalid <= 1'b0;
        end else begin
            wbuf_q <= wbuf_d;
            wbuf_word <= wbuf_word_d;
            pf_tag_q <= pf_tag_d;
            pf_data_q <= pf_data_d;
            pf_valid_q <= pf_valid_d;
            pend_q <= pend_d;
            pend_hi_q <= pend_hi_d;
            sys_rdata <= sys_rdata_d;
            sys_rvalid <= sys_rvalid_d;
        end
    end

    // --------------------
    // Register read port
    // --------------------
    always_comb begin
        rdata_d = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: begin
                    rdata_d[ST_DONE] = done_q;
                    rdata_d[ST_LOCK_ERR] = lock_err_q;
                    rdata_d[ST_BUSY_ERR] = busy_err_q;
                    rdata_d[ST_BUSY_LSB +: 2] = plane_busy;
                end
                REG_CTRL: rdata_d[CTRL_DONE_IE] = done_ie_q;
                REG_LOCK: rdata_d = lock_q & region_mask(small_variant);
                REG_NVM: begin
                    rdata_d[NV_GP_LSB +: 3] = general_nonvolatile_bit_q;
                    rdata_d[NV_SECURITY] = sec_q;
                    rdata_d[NV_REMAP] = remap_q;
                    rdata_d[NV_FAST_PROG] = fast_prog_active;
                end
                REG_CALIB: rdata_d[15:0] = CALIB_VALUE;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // --------------------
    // Outputs
    // --------------------
    assign reg_rdata = rdata_q;
    assign plane_busy = {cnt_q[1] != 16'h0000, cnt_q[0] != 16'h0000};
    assign nvm_prog = prog_q;
    assign nvm_erase_page = erase_pg_q;
    assign nvm_erase_all = erase_all_q;
    assign nvm_page = page_q;
    assign brownout_monitor_en = general_nonvolatile_bit_q[GP_BROWNOUT];
    assign brownout_reset_en = general_nonvolatile_bit_q[GP_BROWNOUT_RST];
    assign remap_done = remap_q;
    assign cmd_irq = lock_err_q | (done_q & done_ie_q);

endmodule : imnp_top
`default_nettype wire

/* testbench/imnp_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module imnp_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic sys_valid,
    input wire logic sys_debug,
    input wire logic [31:0] sys_addr,
    input wire imnp_pkg::imnp_target_type sys_target,
    input wire logic sys_abort,
    input wire logic sys_refused,
    input wire logic wipe_pin,
    input wire logic test_mode_pin,
    input wire logic prog_select_pin_a,
    input wire logic prog_select_pin_b,
    input wire logic prog_select_pin_c,
    input wire logic fast_prog_active,
    input wire logic brownout_monitor_en,
    input wire logic brownout_reset_en,
    input wire logic remap_done
);
    import imnp_pkg::*;
    // --------------------
    // Checks
    // --------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_remap_cmd;
        reg_wr && reg_addr == REG_CMD && reg_wdata[3:0] == OP_REMAP;
    endsequence
    sequence s_wipe;
        wipe_pin [*2];
    endsequence
    sequence s_zero;
        sys_valid && sys_addr[31:20] == 12'h000;
    endsequence
    property p_pre_zero;
        s_zero ##0 !remap_done |-> sys_target != TGT_SRAM;
    endproperty
    a_pre_zero: assert property (p_pre_zero) else $error("sram at zero before remap");
    property p_post_zero;
        s_zero ##0 remap_done |-> sys_target == TGT_SRAM;
    endproperty
    a_post_zero: assert property (p_post_zero) else $error("zero not sram after remap");
    property p_rom;
        sys_valid && sys_addr[31:20] == 12'h003 |-> sys_target == TGT_ROM;
    endproperty
    a_rom: assert property (p_rom) else $error("rom base not decoded");
    property p_flash;
        sys_valid && sys_addr[31:20] == 12'h001 |-> sys_target == TGT_FLASH;
    endproperty
    a_flash: assert property (p_flash) else $error("flash base not decoded");
    property p_abort;
        sys_valid && sys_addr[31:28] inside {[4'h9:4'hE]} |-> sys_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("unused area not aborted");
    property p_refuse;
        sys_refused |-> sys_debug || fast_prog_active;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal without cause");
    property p_fast;
        fast_prog_active == (test_mode_pin && prog_select_pin_a && prog_select_pin_b
            && !prog_select_pin_c);
    endproperty
    a_fast: assert property (p_fast) else $error("fast mode pin pattern");
    property p_remap;
        s_remap_cmd |=> remap_done [*3];
    endproperty
    a_remap: assert property (p_remap) else $error("remap flag not held");
    property p_wipe;
        s_wipe |=> !brownout_monitor_en && !brownout_reset_en;
    endproperty
    a_wipe: assert property (p_wipe) else $error("wipe left brownout bits");
endmodule : imnp_sva
bind imnp_top imnp_sva imnp_sva_i (.*);
`default_nettype wire

/* testbench/imnp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module imnp_flash_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flash_rd_req,
    input wire logic [19:0] flash_rd_addr,
    output logic [63:0] flash_dword,
    output logic flash_dword_valid
);
    // --------------------
    // Array answer
    // --------------------
    // Idle data toggles so a stale pair never passes for fresh
    always_ff @(posedge ref_clk) begin
        flash_dword_valid <= flash_rd_req && !rst;
        if (rst)
            flash_dword <= 64'h0;
        else if (flash_rd_req)
            flash_dword <= {12'hC00, flash_rd_addr | 20'h4, 12'hC00, flash_rd_addr};
        else
            flash_dword <= ~flash_dword;
    end
endmodule : imnp_flash_model
`default_nettype wire

/* testbench/imnp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module imnp_top_tb;
    import imnp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, sys_addr = 32'h0, sys_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sys_valid = 1'b0, sys_write = 1'b0, sys_debug = 1'b0;
    logic [5:0] wbuf_idx = 6'h00;
    logic small_variant = 1'b0, wipe_pin = 1'b0, test_mode_pin = 1'b0;
    logic prog_select_pin_a = 1'b0, prog_select_pin_b = 1'b0, prog_select_pin_c = 1'b0;
    logic [63:0] flash_dword;
    logic flash_dword_valid, sys_abort, sys_refused, flash_wait, flash_rd_req, sys_rvalid;
    logic nvm_prog, nvm_erase_page, nvm_erase_all, fast_prog_active, brownout_monitor_en;
    logic brownout_reset_en, remap_done, cmd_irq;
    logic [31:0] reg_rdata, sys_rdata, wbuf_word;
    logic [19:0] mem_offset, flash_rd_addr;
    logic [PAGE_W-1:0] nvm_page;
    logic [1:0] plane_busy;
    imnp_target_type sys_target;
    int miscompares = 0;
    int total_checks = 0;
    imnp_top imnp_top_i (.*);
    imnp_flash_model imnp_flash_model_i (.*);
    always #20 ref_clk = ~ref_clk;
    // --------------------
    // Bus tasks
    // --------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask : rd
    task automatic cmd(input logic [3:0] op, input logic [10:0] arg);
        wr(REG_CMD, {13'h0, arg, 4'h0, op});
    endtask : cmd
    task automatic acc(input string n, input logic [31:0] a, input logic d,
        input imnp_target_type t, input logic rf);
        @(posedge ref_clk);
        sys_valid <= 1'b1;
        sys_addr <= a;
        sys_debug <= d;
        #1;
        chk(n, 32'(t), 32'(sys_target));
        chk("refused", 32'(rf), 32'(sys_refused));
        @(posedge ref_clk);
        sys_valid <= 1'b0;
    endtask : acc
    task automatic wipe(input int n);
        @(posedge ref_clk);
        wipe_pin <= 1'b1;
        repeat (n) @(posedge ref_clk);
        wipe_pin <= 1'b0;
    endtask : wipe
    task automatic fetch(input logic [31:0] a, input logic [31:0] e);
        int i;
        @(posedge ref_clk);
        sys_valid <= 1'b1;
        sys_addr <= a;
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            sys_valid <= 1'b0;
            #1;
            if (sys_rvalid === 1'b1) break;
        end
        if (i == 8) begin
            miscompares++;
            report_and_stop();
        end
        chk("sys_rdata", e, sys_rdata);
    endtask : fetch
    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset;
        rd("nvm", REG_NVM, 32'h0);
        wr(REG_CALIB, 32'hFFFF_FFFF);
        rd("calib", REG_CALIB, {16'h0, CALIB_VALUE});
        rd("unmapped", 8'h40, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_map;
        acc("zero", 32'h0, 1'b0, TGT_ROM, 1'b0);
        acc("flash", FLASH_BASE, 1'b0, TGT_FLASH, 1'b0);
        acc("rom", ROM_BASE, 1'b0, TGT_ROM, 1'b0);
        acc("sram", SRAM_BASE, 1'b0, TGT_SRAM, 1'b0);
        acc("unused", 32'h9000_0000, 1'b0, TGT_ABORT, 1'b0);
        cmd(OP_SET_GENERAL_NONVOLATILE_BIT, 11'd2);
        acc("zero", 32'h0, 1'b0, TGT_FLASH, 1'b0);
        cmd(OP_REMAP, 11'd0);
        acc("zero", 32'h0, 1'b0, TGT_SRAM, 1'b0);
        acc("sram", SRAM_BASE, 1'b0, TGT_SRAM, 1'b0);
        rd("nvm", REG_NVM, 32'h104);
        $display("t_map done");
    endtask : t_map
    task automatic t_wipe;
        cmd(OP_SET_GENERAL_NONVOLATILE_BIT, 11'd0);
        cmd(OP_SET_GENERAL_NONVOLATILE_BIT, 11'd1);
        cmd(OP_SET_LOCK, 11'd64);
        rd("lock", REG_LOCK, 32'h2);
        wipe(20);
        rd("nvm", REG_NVM, 32'h100);
        rd("lock", REG_LOCK, 32'h0);
        $display("t_wipe done");
    endtask : t_wipe
    task automatic t_lock;
        cmd(OP_SET_LOCK, 11'd64);
        cmd(OP_PROG_PAGE, 11'd64);
        #1;
        chk("nvm_prog", 32'h0, 32'(nvm_prog));
        chk("cmd_irq", 32'h1, 32'(cmd_irq));
        rd("status", REG_STATUS, 32'h3);
        cmd(OP_CLR_LOCK, 11'd64);
        cmd(OP_PROG_PAGE, 11'd64);
        #1;
        chk("nvm_prog", 32'h1, 32'(nvm_prog));
        repeat (20) @(posedge ref_clk);
        small_variant <= 1'b1;
        cmd(OP_SET_LOCK, 11'd32);
        cmd(OP_ERASE_PAGE, 11'd32);
        #1;
        chk("nvm_erase_page", 32'h0, 32'(nvm_erase_page));
        rd("lock", REG_LOCK, 32'h2);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_secure;
        cmd(OP_SET_SECURITY, 11'd0);
        rd("nvm", REG_NVM, 32'h110);
        acc("debug", FLASH_BASE, 1'b1, TGT_FLASH, 1'b1);
        test_mode_pin <= 1'b1;
        prog_select_pin_a <= 1'b1;
        prog_select_pin_b <= 1'b1;
        acc("fast", FLASH_BASE, 1'b0, TGT_FLASH, 1'b1);
        prog_select_pin_c <= 1'b1;
        acc("normal", FLASH_BASE, 1'b0, TGT_FLASH, 1'b0);
        wipe(24);
        rd("nvm", REG_NVM, 32'h100);
        acc("debug", FLASH_BASE, 1'b1, TGT_FLASH, 1'b0);
        $display("t_secure done");
    endtask : t_secure
    task automatic t_read;
        sys_write <= 1'b1;
        sys_wdata <= 32'h5A5A_1234;
        wbuf_idx <= 6'h02;
        acc("wbuf", FLASH_BASE + 32'h8, 1'b0, TGT_FLASH, 1'b0);
        sys_write <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("wbuf_word", 32'h5A5A_1234, wbuf_word);
        fetch(FLASH_BASE + 32'h8, 32'hC000_0008);
        fetch(FLASH_BASE + 32'hC, 32'hC000_000C);
        $display("t_read done");
    endtask : t_read
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_map();
        t_wipe();
        t_lock();
        t_secure();
        t_read();
        report_and_stop();
    end
endmodule : imnp_top_tb
`default_nettype wire
